// [logic/pat_pkg.sv]
// pat_pkg: register map, field positions and counts for the pulse
// accumulator and periodic tick block.
// assumes a 32-bit apb bus with byte addresses on paddr.
package pat_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_FLAG  = 8'h00;
   localparam logic [7:0] OFS_CTRL  = 8'h04;
   localparam logic [7:0] OFS_COUNT = 8'h08;
   localparam logic [7:0] OFS_MASK  = 8'h0c;

   // flag and mask bit positions (shared layout)
   localparam int BIT_CWRAP = 7;
   localparam int BIT_TICK  = 6;
   localparam int BIT_AWRAP = 5;
   localparam int BIT_AEDGE = 4;

   // control register fields
   localparam int BIT_AEN   = 6;
   localparam int BIT_AGATE = 5;
   localparam int BIT_APOL  = 4;
   localparam int BIT_C4C5  = 2;
   localparam int RATE_LSB  = 0;

   // writable bits and reset values
   localparam logic [7:0] CTRL_WMASK = 8'h77;
   localparam logic [7:0] MASK_WMASK = 8'hf3;
   localparam logic [7:0] FLAG_IMPL  = 8'hf0;
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] MASK_RST   = 8'h00;
   localparam logic [7:0] FLAG_RST   = 8'h00;

   // divider chain
   localparam int TICK_BASE_LOG2 = 13;
   localparam int DIV_W          = 16;
   localparam int GATE_DIV       = 64;
   localparam logic [15:0] GATE_MASK = 16'(GATE_DIV - 1);

endpackage : pat_pkg

// [logic/pat_top.sv]
// pat_top: pulse accumulator, periodic tick divider, free running
// counter wrap flag, and their flag/mask/control registers on apb.
// assumes one clock, a synchronous active-low reset, and an
// accumulator pin that is asynchronous to clk.
//
// What this block does
// - counter wrap sets flag bit 7
// - tick period end sets bit 6
// - flags clear only by writing one
// - flag bits three to zero read zero
// - tick base is clock over 2^13
// - rate select gives 2^13 to 2^16
// - divider free running, first tick one period
// - tick enable gates tick request
// - accumulator enable turns counting on
// - event mode counts selected pin edge
// - gated mode counts clock/64 ticks
// - polarity bit picks inhibiting pin level
// - select bit picks capture4 or compare5
// - count readable, writable, reset-free
// - count readable while gate inactive
// - increments and reads never collide
// - count wrap sets flag bit 5
// - wrap enable gates request, not flag
// - selected pin edge sets bit 4
// - edge enable gates request, not flag
//
// Decided for this implementation: the register addresses and the APB interface to the registers.

`timescale 1ns/100ps

module pat_top
   import pat_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        accum_input_pin,
   output logic [3:0]       timer_irq_req,
   output logic             capture4_compare5_select
);

   ////////////////////////////////////////////////////////////////
   // state

   logic [7:0]       flag_q;
   logic [7:0]       ctrl_q;
   logic [7:0]       mask_q;
   logic [7:0]       count_q;
   logic [15:0]      frc_q;
   logic [DIV_W-1:0] div_q;
   logic             pin_s1_q;
   logic             pin_s2_q;
   logic             pin_prev_q;

   ////////////////////////////////////////////////////////////////
   // bus decode

   logic acc_req;
   logic acc_done;
   logic wr_done;
   logic hit_flag;
   logic hit_ctrl;
   logic hit_count;
   logic hit_mask;
   logic hit_any;

   // a transfer completes on the edge where pready is seen high
   assign acc_req   = psel & penable & ~pready;
   assign acc_done  = psel & penable & pready;
   assign wr_done   = acc_done & pwrite;
   assign hit_flag  = (paddr == OFS_FLAG);
   assign hit_ctrl  = (paddr == OFS_CTRL);
   assign hit_count = (paddr == OFS_COUNT);
   assign hit_mask  = (paddr == OFS_MASK);
   assign hit_any   = hit_flag | hit_ctrl | hit_count | hit_mask;

   // one wait state so read data can come from a flip-flop
   always_ff @(posedge clk)
   begin
      if (!resetn)
         pready <= 1'b0;
      else
         pready <= acc_req;
   end

   // unmapped addresses answer with an error and zero data
   always_ff @(posedge clk)
   begin
      if (!resetn)
         pslverr <= 1'b0;
      else if (acc_req)
         pslverr <= ~hit_any;
      else
         pslverr <= 1'b0;
   end

   // read data captured in the first access cycle
   always_ff @(posedge clk)
   begin
      if (!resetn)
         prdata <= 32'h0000_0000;
      else if (acc_req && !pwrite)
      begin
         prdata <= 32'h0000_0000;
         if (hit_flag)
            prdata[7:0] <= flag_q & FLAG_IMPL;
         if (hit_ctrl)
            prdata[7:0] <= ctrl_q;
         if (hit_count)
            prdata[7:0] <= count_q;
         if (hit_mask)
            prdata[7:0] <= mask_q;
      end
      else
         prdata <= 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////
   // control and mask registers

   always_ff @(posedge clk)
   begin
      if (!resetn)
         ctrl_q <= CTRL_RST;
      else if (wr_done && hit_ctrl)
         ctrl_q <= pwdata[7:0] & CTRL_WMASK;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         mask_q <= MASK_RST;
      else if (wr_done && hit_mask)
         mask_q <= pwdata[7:0] & MASK_WMASK;
   end

   logic       acc_en;
   logic       acc_gated;
   logic       acc_pol;
   logic [1:0] rate_sel;

   assign acc_en    = ctrl_q[BIT_AEN];
   assign acc_gated = ctrl_q[BIT_AGATE];
   assign acc_pol   = ctrl_q[BIT_APOL];
   assign rate_sel  = ctrl_q[RATE_LSB +: 2];

   // drives the compare5/capture4 mux in the timer core
   always_ff @(posedge clk)
   begin
      if (!resetn)
         capture4_compare5_select <= 1'b0;
      else
         capture4_compare5_select <= ctrl_q[BIT_C4C5];
   end

   ////////////////////////////////////////////////////////////////
   // free running counter and divider chain

   logic frc_wrap;

   always_ff @(posedge clk)
   begin
      if (!resetn)
         frc_q <= 16'h0000;
      else
         frc_q <= frc_q + 16'h0001;
   end

   assign frc_wrap = (frc_q == 16'hffff);

   // never stopped except by reset, so periods do not depend on
   // when software clears the flag
   always_ff @(posedge clk)
   begin
      if (!resetn)
         div_q <= '0;
      else
         div_q <= div_q + DIV_W'(1);
   end

   logic [DIV_W-1:0] tick_mask;
   logic             tick_hit;
   logic             gate_tick;

   // low 13 to 16 bits all ones marks the end of a period
   always_comb
   begin
      tick_mask = DIV_W'((32'd1 << (TICK_BASE_LOG2 +
                   int'(rate_sel))) - 32'd1);
   end

   assign tick_hit  = ((div_q & tick_mask) == tick_mask);
   assign gate_tick = ((div_q & GATE_MASK) == GATE_MASK);

   ////////////////////////////////////////////////////////////////
   // accumulator pin synchroniser and edge detect

   // pin is asynchronous; the edge rule for the source keeps each
   // level at least two clocks so no edge is missed
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         pin_s1_q   <= 1'b0;
         pin_s2_q   <= 1'b0;
         pin_prev_q <= 1'b0;
      end
      else
      begin
         pin_s1_q   <= accum_input_pin;
         pin_s2_q   <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
      end
   end

   logic pin_rise;
   logic pin_fall;
   logic sel_edge;
   logic gate_open;
   logic acc_inc;

   assign pin_rise  = pin_s2_q & ~pin_prev_q;
   assign pin_fall  = ~pin_s2_q & pin_prev_q;
   assign sel_edge  = acc_pol ? pin_rise : pin_fall;
   // polarity names the level that inhibits counting
   assign gate_open = pin_s2_q ^ acc_pol;

   always_comb
   begin
      acc_inc = 1'b0;
      if (acc_en)
      begin
         if (acc_gated)
            acc_inc = gate_tick & gate_open;
         else
            acc_inc = sel_edge;
      end
   end

   ////////////////////////////////////////////////////////////////
   // accumulator count, deliberately outside reset

   logic acc_wrap;

   assign acc_wrap = acc_inc & (count_q == 8'hff);

   // a software write wins over an increment in the same cycle;
   // reads were sampled one edge earlier, so a read never sees a
   // half-updated count
   always_ff @(posedge clk)
   begin
      if (wr_done && hit_count)
         count_q <= pwdata[7:0];
      else if (acc_inc)
         count_q <= count_q + 8'h01;
   end

   ////////////////////////////////////////////////////////////////
   // flag register

   logic [7:0] flag_set;
   logic [7:0] flag_clr;

   always_comb
   begin
      flag_set            = 8'h00;
      flag_set[BIT_CWRAP] = frc_wrap;
      flag_set[BIT_TICK]  = tick_hit;
      flag_set[BIT_AWRAP] = acc_wrap;
      flag_set[BIT_AEDGE] = acc_en & sel_edge;
   end

   // ones clear, zeros keep; a same-cycle set beats the clear
   assign flag_clr = (wr_done && hit_flag) ?
                     (pwdata[7:0] & FLAG_IMPL) : 8'h00;

   always_ff @(posedge clk)
   begin
      if (!resetn)
         flag_q <= FLAG_RST;
      else
         flag_q <= ((flag_q & ~flag_clr) | flag_set) & FLAG_IMPL;
   end

   ////////////////////////////////////////////////////////////////
   // request outputs, one per flag bit 7..4

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_req
         // mask never touches the flag, only its request
         always_ff @(posedge clk)
         begin
            if (!resetn)
               timer_irq_req[gi] <= 1'b0;
            else
               timer_irq_req[gi] <= flag_q[gi+4] &
                                    mask_q[gi+4];
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // checks

   chk_cwrap_set: assert property (
      @(posedge clk) disable iff (!resetn)
      frc_q == 16'hffff |=> flag_q[BIT_CWRAP])
      else $error("counter wrap flag not set");

   chk_tick_set: assert property (
      @(posedge clk) disable iff (!resetn)
      tick_hit |=> flag_q[BIT_TICK])
      else $error("tick flag not set at period end");

   chk_tick_base: assert property (
      @(posedge clk) disable iff (!resetn)
      tick_hit |-> div_q[TICK_BASE_LOG2-1:0] == 13'h1fff)
      else $error("tick outside base period");

   chk_flag_clear: assert property (
      @(posedge clk) disable iff (!resetn)
      wr_done && hit_flag && pwdata[BIT_AEDGE] &&
      !flag_set[BIT_AEDGE] |=> !flag_q[BIT_AEDGE])
      else $error("edge flag not cleared by one");

   chk_flag_keep: assert property (
      @(posedge clk) disable iff (!resetn)
      flag_q[BIT_AWRAP] && !(wr_done && hit_flag &&
      pwdata[BIT_AWRAP]) |=> flag_q[BIT_AWRAP])
      else $error("wrap flag lost without a one");

   chk_low_zero: assert property (
      @(posedge clk) disable iff (!resetn)
      acc_req && !pwrite && hit_flag |=> prdata[3:0] == 4'h0)
      else $error("flag low bits not zero");

   chk_event_inc: assert property (
      @(posedge clk) disable iff (!resetn)
      acc_en && !acc_gated && sel_edge && !(wr_done && hit_count)
      |=> count_q == $past(count_q) + 8'h01)
      else $error("event edge not counted");

   chk_gate_hold: assert property (
      @(posedge clk) disable iff (!resetn)
      acc_gated && !gate_open && !(wr_done && hit_count)
      |=> count_q == $past(count_q))
      else $error("count moved while gate shut");

   chk_awrap_set: assert property (
      @(posedge clk) disable iff (!resetn)
      acc_inc && count_q == 8'hff && !(wr_done && hit_count)
      |=> count_q == 8'h00 && flag_q[BIT_AWRAP])
      else $error("count wrap flag not set");

   chk_edge_flag: assert property (
      @(posedge clk) disable iff (!resetn)
      acc_en && sel_edge |=> flag_q[BIT_AEDGE])
      else $error("edge flag not set");

   chk_req_gate: assert property (
      @(posedge clk) disable iff (!resetn)
      ##1 timer_irq_req[0] == ($past(flag_q[BIT_AEDGE]) &&
      $past(mask_q[BIT_AEDGE])))
      else $error("edge request not gated by mask");

   chk_tick_req: assert property (
      @(posedge clk) disable iff (!resetn)
      flag_q[BIT_TICK] && mask_q[BIT_TICK] |=> timer_irq_req[2])
      else $error("tick request missing");

   chk_apb_wait: assert property (
      @(posedge clk) disable iff (!resetn)
      acc_req |=> pready ##1 !pready)
      else $error("pready not one cycle after access");

endmodule : pat_top

// [sim/pat_pin_model.sv]
// pat_pin_model: drives the accumulator input pin in pulse bursts.
// assumes the bench raises start for one clock and then waits on busy.

`timescale 1ns/100ps

module pat_pin_model (
   input  wire logic       clk,
   input  wire logic       start,
   input  wire logic [7:0] pulses,
   input  wire logic       idle_level,
   output logic            pin,
   output logic            busy
);
   ////////////////////////////////////////////////////////////////////
   // each level holds 3 clocks, so the pin never outruns clock/2
   initial
   begin
      pin  = 1'b0;
      busy = 1'b0;
      forever
      begin
         @(posedge clk);
         if (start)
         begin
            busy <= 1'b1;
            repeat (pulses)
            begin
               pin <= ~idle_level;
               repeat (3) @(posedge clk);
               pin <= idle_level;
               repeat (3) @(posedge clk);
            end
            busy <= 1'b0;
         end
         else
            pin <= idle_level;
      end
   end
endmodule : pat_pin_model

// [sim/pat_top_tb.sv]
// pat_top_tb: register, accumulator and tick tests over apb.
// assumes pat_top with one wait state and the pin model beside it.

`timescale 1ns/100ps

module pat_top_tb;
   import pat_pkg::*;

   logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, pulses;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  irq;
   logic        c45, pin, start, idle, busy, er;
   int          fails, tests_run, cyc, t0, t1;

   pat_top DUT (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .accum_input_pin(pin), .timer_irq_req(irq),
      .capture4_compare5_select(c45));

   pat_pin_model pm (.clk(clk), .start(start), .pulses(pulses),
      .idle_level(idle), .pin(pin), .busy(busy));

   ////////////////////////////////////////////////////////////////////
   // 25 ns clock and a cycle count for period checks
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   ////////////////////////////////////////////////////////////////////
   // one apb transfer; waits on pready, never a fixed count
   task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never gets an answer
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : acc

   // one extra edge lets registered copies of the new value settle
   task wr(input logic [7:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
      @(posedge clk);
   endtask : wr

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task chk_rng(input string nm, input int lo, input int hi,
                input logic [31:0] g);
      tests_run++;
      if ((^g === 1'bx) || g < lo || g > hi)
      begin
         fails++;
         $display("CHECK FAILED %s expected %0d..%0d seen %h", nm, lo, hi, g);
      end
   endtask : chk_rng

   // read with mask; upper data bits must read zero as well
   task rchk(input string nm, input logic [7:0] a, input logic [7:0] e,
             input logic [7:0] m);
      acc(1'b0, a, 8'h00);
      chk(nm, {24'h0, e & m}, rd & {24'hffffff, m});
   endtask : rchk

   // a burst of pulses, then time for the pin synchroniser
   task burst(input logic [7:0] n);
      pulses <= n;
      start  <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (2) @(posedge clk);
      while (busy === 1'b1)
         @(posedge clk);
      repeat (6) @(posedge clk);
   endtask : burst

   // waits for the tick request; skips the edges a clear needs to land
   task wait_tick(output int t);
      repeat (3) @(posedge clk);
      while (irq[2] !== 1'b1)
         @(posedge clk);
      t = cyc;
   endtask : wait_tick

   task wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up

   ////////////////////////////////////////////////////////////////////
   // watchdog: a clean run ends near cycle 66000, the tick waits
   // being nearly all of it
   initial
   begin
      repeat (90000) @(posedge clk);
      fails++;
      wrap_up;
   end

   ////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      {resetn, psel, penable, pwrite, start} = 5'h0;
      {paddr, pulses, pwdata} = '0;
      {fails, tests_run, cyc} = '0;
      idle = 1'b1;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rchk("flag reset", OFS_FLAG, 8'h00, 8'hff);
      rchk("ctrl reset", OFS_CTRL, 8'h00, 8'hff);
      rchk("mask reset", OFS_MASK, 8'h00, 8'hff);
      acc(1'b0, 8'h10, 8'h00);
      chk("unmapped err", 32'h1, {31'h0, er});
      chk("unmapped data", 32'h0, rd);
      // count has no reset; give it a value before any mode can move it
      wr(OFS_COUNT, 8'h00);
      wr(OFS_CTRL, 8'hff);
      rchk("ctrl bits", OFS_CTRL, 8'h77, 8'hff);
      chk("c45 set", 32'h1, {31'h0, c45});
      wr(OFS_CTRL, 8'h00);
      chk("c45 clear", 32'h0, {31'h0, c45});
      wr(OFS_MASK, 8'hff);
      rchk("mask bits", OFS_MASK, 8'hf3, 8'hff);
      wr(OFS_MASK, 8'h00);
      wr(OFS_FLAG, 8'hff);
      rchk("flag low", OFS_FLAG, 8'h00, 8'h0f);
      $display("test registers done");
      // falling edges from fd roll the count over
      wr(OFS_COUNT, 8'hfd);
      rchk("count rw", OFS_COUNT, 8'hfd, 8'hff);
      wr(OFS_CTRL, 8'h40);
      burst(8'd4);
      rchk("fall count", OFS_COUNT, 8'h01, 8'hff);
      rchk("wrap edge", OFS_FLAG, 8'h30, 8'h30);
      wr(OFS_MASK, 8'h30);
      chk("acc req", 32'h3, {30'h0, irq[1:0]});
      wr(OFS_FLAG, 8'h10);
      rchk("one clear", OFS_FLAG, 8'h20, 8'h30);
      chk("req follow", 32'h2, {30'h0, irq[1:0]});
      wr(OFS_MASK, 8'h00);
      // rising edges; the set-up fall must not count
      wr(OFS_CTRL, 8'h50);
      idle <= 1'b0;
      repeat (6) @(posedge clk);
      burst(8'd2);
      rchk("rise count", OFS_COUNT, 8'h03, 8'hff);
      // disabled: no count and no edge flag
      wr(OFS_CTRL, 8'h00);
      wr(OFS_FLAG, 8'h30);
      burst(8'd3);
      rchk("off count", OFS_COUNT, 8'h03, 8'hff);
      rchk("off flag", OFS_FLAG, 8'h00, 8'h10);
      $display("test event done");
      // gated time for both polarities: 640 clocks is ten ticks
      for (int p = 0; p < 2; p++)
      begin
         idle <= p[0];
         wr(OFS_CTRL, p[0] ? 8'h70 : 8'h60);
         wr(OFS_COUNT, 8'h00);
         repeat (640) @(posedge clk);
         rchk("gate hold", OFS_COUNT, 8'h00, 8'hff);
         idle <= ~p[0];
         repeat (640) @(posedge clk);
         idle <= p[0];
         repeat (8) @(posedge clk);
         acc(1'b0, OFS_COUNT, 8'h00);
         chk_rng("gate count", 9, 11, rd);
      end
      $display("test gated done");
      // tick periods for rate codes 0 to 2, measured on the request;
      // the divider is free, so the second rate 0 tick also ends a
      // rate 1 period and that one a rate 2 period: this must start
      // before the first rate 0 tick to keep the run short
      wr(OFS_MASK, 8'h40);
      wr(OFS_CTRL, 8'h00);
      wr(OFS_FLAG, 8'h40);
      wait_tick(t0);
      wr(OFS_FLAG, 8'h40);
      wait_tick(t1);
      chk("tick period 0", 32'h0000_2000, 32'(t1 - t0));
      wr(OFS_CTRL, 8'h01);
      wr(OFS_FLAG, 8'h40);
      wait_tick(t0);
      chk("tick period 1", 32'h0000_4000, 32'(t0 - t1));
      wr(OFS_CTRL, 8'h02);
      wr(OFS_FLAG, 8'h40);
      wait_tick(t1);
      chk("tick period 2", 32'h0000_8000, 32'(t1 - t0));
      wr(OFS_CTRL, 8'h03);
      rchk("rate top", OFS_CTRL, 8'h03, 8'hff);
      wr(OFS_MASK, 8'h00);
      chk("tick masked", 32'h0, {31'h0, irq[2]});
      rchk("tick flag", OFS_FLAG, 8'h40, 8'h40);
      $display("test tick done");
      // the counter has wrapped by now
      rchk("cnt wrap", OFS_FLAG, 8'h80, 8'h80);
      wr(OFS_MASK, 8'h80);
      chk("wrap req", 32'h1, {31'h0, irq[3]});
      wr(OFS_FLAG, 8'h80);
      rchk("wrap clear", OFS_FLAG, 8'h00, 8'h80);
      $display("test wrap done");
      wrap_up;
   end
endmodule : pat_top_tb
